// [bench/pwr_mode_ctrl_tb.sv]
// self-checking testbench for the idle and stop power mode controller
module pwr_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // short warm-up keeps the run brief; expectations derive from it
  localparam int WARM = 8;
  localparam logic [7:0] PCR = pwr_mode_pkg::IDX_POWER_CONTROL;
  localparam logic [7:0] EFR = pwr_mode_pkg::IDX_EXT_INT_FLAG;
  localparam logic [7:0] STR = pwr_mode_pkg::IDX_MODE_STATUS;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic ext_program_exec = 1'b0;
  logic req_stb = 1'b0;
  logic [2:0] req_code = 3'h0;
  logic [31:0] rdat;
  logic ack, irq_en, e_irq, pf_irq, x_rst, w_rst, s_rst, p_rst;
  logic core_hold, core_rst, clk_gate_off, xtal_amp_en, bandgap_en;
  logic take_vector, restart_zero, p0_drive_opcode, p2_hold_latched;
  logic [4:0] ctl;
  logic [7:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  int c;

  assign ctl = {core_hold, core_rst, clk_gate_off, xtal_amp_en, bandgap_en};
  always #50 core_clk = ~core_clk;

  pwr_mode_ctrl #(.WARM_CYCLES(WARM)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_enabled_any(irq_en),
    .ext_irq(e_irq), .pfail_irq(pf_irq), .ext_rst_pin(x_rst), .wdt_rst(w_rst),
    .supply_low_rst(s_rst), .power_on_rst(p_rst), .ext_program_exec(ext_program_exec),
    .core_hold(core_hold), .core_rst(core_rst), .clk_gate_off(clk_gate_off),
    .xtal_amp_en(xtal_amp_en), .bandgap_en(bandgap_en), .take_vector(take_vector),
    .restart_zero(restart_zero), .p0_drive_opcode(p0_drive_opcode),
    .p2_hold_latched(p2_hold_latched));

  wake_src_model src (.core_clk(core_clk), .sys_rst(sys_rst), .req_stb(req_stb),
    .req_code(req_code), .take_vector(take_vector), .irq_enabled_any(irq_en),
    .ext_irq(e_irq), .pfail_irq(pf_irq), .ext_rst_pin(x_rst), .wdt_rst(w_rst),
    .supply_low_rst(s_rst), .power_on_rst(p_rst));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  // classic cycle: hold everything until ack is sampled, then release
  task wb_rw(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge core_clk);
    {cyc, stb, we, sel} <= {3'b110 | {2'b00, w}, 4'hF};
    adr <= {22'h0, idx, 2'b00};
    wdat <= {24'h0, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge core_clk);
    rd = rdat[7:0];
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1)
    begin
      fail_count++;
      stop_test;
    end
    @(posedge core_clk);
  endtask : wb_rw

  task rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] msk, exp);
    wb_rw(1'b0, idx, 8'h00);
    check(nm, rd & msk, exp);
  endtask : rd_chk

  task cause(input logic [2:0] code);
    @(posedge core_clk);
    req_stb <= 1'b1;
    req_code <= code;
    @(posedge core_clk);
    req_stb <= 1'b0;
  endtask : cause

  // sel 0 waits for the vector pulse, sel 1 for the restart pulse
  task wait_pulse(input logic s);
    for (n = 1; n < 300; n++)
    begin
      @(posedge core_clk);
      if ((s ? restart_zero : take_vector) === 1'b1)
        return;
    end
    fail_count++;
    stop_test;
  endtask : wait_pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("ctl_run", 8'(ctl), 8'h03);
    rd_chk("power_control", PCR, 8'hFF, 8'h00);
    rd_chk("ext_int_flag", EFR, 8'hFF, 8'h00);
    rd_chk("mode_status", STR, 8'h1F, 8'h01);
    wb_rw(1'b1, 8'h10, 8'h5A);
    rd_chk("unmapped", 8'h10, 8'hFF, 8'h00);
    $display("test reset done");
    ext_program_exec <= 1'b1;
    wb_rw(1'b1, PCR, 8'h01);
    check("ctl_idle", 8'(ctl), 8'h13);
    check("ports_idle", 8'({p0_drive_opcode, p2_hold_latched}), 8'h03);
    rd_chk("status_idle", STR, 8'h1F, 8'h02);
    cause(3'h3);
    wait_pulse(1'b0);
    check("ctl_wake", 8'(ctl), 8'h03);
    rd_chk("idle_bit", PCR, 8'hFF, 8'h00);
    check("ports_run", 8'({p0_drive_opcode, p2_hold_latched}), 8'h00);
    ext_program_exec <= 1'b0;
    for (c = 4; c < 8; c++)
    begin
      wb_rw(1'b1, PCR, 8'h01);
      cause(3'(c));
      repeat (2) @(posedge core_clk);
      check("idle_rst_hold", 8'(ctl), 8'h0B);
      wait_pulse(1'b1);
      check("idle_rst_fast", 8'(n < WARM), 8'h01);
      rd_chk("idle_rst_bit", PCR, 8'hFF, 8'h00);
    end
    $display("test idle done");
    wb_rw(1'b1, PCR, 8'h02);
    check("ctl_stop", 8'(ctl), 8'h14);
    for (c = 2; c < 7; c++)
    begin
      cause(3'(c));
      repeat (WARM + 4) @(posedge core_clk);
      check("stop_ignore", 8'(ctl), 8'h14);
      c = (c == 3) ? 4 : c;
    end
    cause(3'h0);
    cause(3'h1);
    wait_pulse(1'b0);
    check("warm_delay", 8'(n >= WARM && n <= WARM + 3), 8'h01);
    rd_chk("status_wake", STR, 8'h3F, 8'h21);
    wb_rw(1'b1, PCR, 8'h02);
    cause(3'h4);
    wait_pulse(1'b1);
    check("pin_exit", 8'(n >= WARM), 8'h01);
    rd_chk("status_pin", STR, 8'h1F, 8'h01);
    $display("test stop done");
    wb_rw(1'b1, EFR, 8'h01);
    wb_rw(1'b1, PCR, 8'h02);
    check("ctl_keep", 8'(ctl), 8'h15);
    cause(3'h2);
    wait_pulse(1'b0);
    check("pfail_wake", 8'(ctl), 8'h03);
    wb_rw(1'b1, PCR, 8'h02);
    cause(3'h6);
    wait_pulse(1'b1);
    rd_chk("dip_reset", STR, 8'h1F, 8'h01);
    wb_rw(1'b1, EFR, 8'h02);
    cause(3'h5);
    wait_pulse(1'b1);
    rd_chk("ring_kept", EFR, 8'hFF, 8'h02);
    wb_rw(1'b1, PCR, 8'h02);
    cause(3'h1);
    wait_pulse(1'b0);
    check("ring_fast", 8'(n <= 4), 8'h01);
    wb_rw(1'b1, PCR, 8'h02);
    cause(3'h7);
    wait_pulse(1'b1);
    rd_chk("por_clear", EFR, 8'hFF, 8'h00);
    $display("test keep alive done");
    wb_rw(1'b1, PCR, 8'h03);
    rd_chk("both_bits", STR, 8'h1F, 8'h04);
    cause(3'h1);
    wait_pulse(1'b0);
    check("both_exit", 8'(n >= WARM), 8'h01);
    $display("test both bits done");
    stop_test;
  end
endmodule : pwr_mode_ctrl_tb

// [bench/wake_src_model.sv]
// interrupt and reset source model on the far side of the power mode controller
module wake_src_model #(
  parameter int RST_LEN = 3
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req_stb,
  input wire logic [2:0] req_code,
  input wire logic take_vector,
  output logic irq_enabled_any,
  output logic ext_irq,
  output logic pfail_irq,
  output logic ext_rst_pin,
  output logic wdt_rst,
  output logic supply_low_rst,
  output logic power_on_rst
);
  int rst_cnt;

  // ----------------------------------------------------------------
  // interrupt lines: levels held until the core takes the vector or request code 0 clears them
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      {ext_irq, pfail_irq, irq_enabled_any} <= 3'h0;
    else if (take_vector || (req_stb && req_code == 3'h0))
      {ext_irq, pfail_irq, irq_enabled_any} <= 3'h0;
    else if (req_stb && !req_code[2])
      {ext_irq, pfail_irq, irq_enabled_any} <=
        {ext_irq, pfail_irq, irq_enabled_any} | 3'(4'h8 >> req_code[1:0]);
  end

  // ----------------------------------------------------------------
  // reset lines: fixed-length pulses, since the controller waits for them to fall
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_cnt <= 0;
      {ext_rst_pin, wdt_rst, supply_low_rst, power_on_rst} <= 4'h0;
    end
    else if (req_stb && req_code[2])
    begin
      // watchdog may fire even while idle
      rst_cnt <= RST_LEN;
      {ext_rst_pin, wdt_rst, supply_low_rst, power_on_rst} <= 4'h8 >> req_code[1:0];
    end
    else if (rst_cnt > 1)
      rst_cnt <= rst_cnt - 1;
    else
    begin
      rst_cnt <= 0;
      {ext_rst_pin, wdt_rst, supply_low_rst, power_on_rst} <= 4'h0;
    end
  end
endmodule : wake_src_model

// [verilog/pwr_mode_ctrl.sv]
// idle and stop power mode controller with wishbone register slave
module pwr_mode_ctrl #(
  parameter int WARM_CYCLES = pwr_mode_pkg::WARM_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt and reset sources
  input wire logic irq_enabled_any,
  input wire logic ext_irq,
  input wire logic pfail_irq,
  input wire logic ext_rst_pin,
  input wire logic wdt_rst,
  input wire logic supply_low_rst,
  input wire logic power_on_rst,
  input wire logic ext_program_exec,
  // core and clock controls
  output logic core_hold,
  output logic core_rst,
  output logic clk_gate_off,
  output logic xtal_amp_en,
  output logic bandgap_en,
  output logic take_vector,
  output logic restart_zero,
  output logic p0_drive_opcode,
  output logic p2_hold_latched
);

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  generate
    if (WARM_CYCLES < 1 || WARM_CYCLES > (1 << pwr_mode_pkg::WARM_CNT_W))
    begin : g_bad_warm
      $error("WARM_CYCLES out of range");
    end
  endgenerate

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  logic [7:0] bus_idx;
  logic bus_req;
  logic bus_wr;
  logic wr_pc;
  logic wr_ef;

  assign bus_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_pc = bus_wr && bus_idx == pwr_mode_pkg::IDX_POWER_CONTROL;
  assign wr_ef = bus_wr && bus_idx == pwr_mode_pkg::IDX_EXT_INT_FLAG;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  // local copy of the counter width, declared before the cast that needs it
  localparam int WARM_CNT_W = pwr_mode_pkg::WARM_CNT_W;
  pwr_mode_pkg::mode_state_t state_r;
  pwr_mode_pkg::mode_state_t state_nxt;
  logic [7:0] power_control_r;
  logic [7:0] ext_int_flag_r;
  logic [pwr_mode_pkg::WARM_CNT_W-1:0] warm_cnt_r;
  logic wake_by_irq_r;
  logic keep_alive;
  logic ring_sel;
  logic run_rst;
  logic stop_rst;
  logic stop_wake_irq;
  logic warm_done;

  assign keep_alive = ext_int_flag_r[pwr_mode_pkg::EF_KEEP_ALIVE_BIT];
  assign ring_sel = ext_int_flag_r[pwr_mode_pkg::EF_RING_SEL_BIT];
  // watchdog stays a reset source while awake, idle included
  assign run_rst = ext_rst_pin || wdt_rst || supply_low_rst || power_on_rst;
  // no clocks in stop, so the watchdog has no say here
  assign stop_rst = ext_rst_pin || power_on_rst || (supply_low_rst && keep_alive);
  assign stop_wake_irq = ext_irq || (pfail_irq && keep_alive);
  // ring select skips the crystal wait; the ring oscillator itself is outside
  assign warm_done = ring_sel || warm_cnt_r == WARM_CNT_W'(WARM_CYCLES - 1);

  // --------------------------------------------------------------
  // mode sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pwr_mode_pkg::ST_RUN:
      begin
        if (run_rst)
          state_nxt = pwr_mode_pkg::ST_RESET;
        else if (wr_pc && wb_dat_i[pwr_mode_pkg::PC_STOP_BIT])
          state_nxt = pwr_mode_pkg::ST_STOP;
        else if (wr_pc && wb_dat_i[pwr_mode_pkg::PC_IDLE_BIT])
          state_nxt = pwr_mode_pkg::ST_IDLE;
      end
      pwr_mode_pkg::ST_IDLE:
      begin
        if (run_rst)
          state_nxt = pwr_mode_pkg::ST_RESET;
        else if (irq_enabled_any)
          state_nxt = pwr_mode_pkg::ST_RUN;
      end
      pwr_mode_pkg::ST_STOP:
      begin
        if (stop_rst || stop_wake_irq)
          state_nxt = pwr_mode_pkg::ST_WARM;
      end
      pwr_mode_pkg::ST_WARM:
      begin
        if (warm_done)
          state_nxt = wake_by_irq_r ? pwr_mode_pkg::ST_RUN : pwr_mode_pkg::ST_RESET;
      end
      pwr_mode_pkg::ST_RESET:
      begin
        if (!run_rst)
          state_nxt = pwr_mode_pkg::ST_RUN;
      end
      default:
        state_nxt = pwr_mode_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= pwr_mode_pkg::ST_RESET;
    else
      state_r <= state_nxt;
  end

  // reset wins over interrupt when both arrive in the same stop cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wake_by_irq_r <= 1'b0;
    else if (state_r == pwr_mode_pkg::ST_STOP)
      wake_by_irq_r <= !stop_rst && stop_wake_irq;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      warm_cnt_r <= '0;
    else if (state_r == pwr_mode_pkg::ST_WARM)
      warm_cnt_r <= warm_cnt_r + 1'b1;
    else
      warm_cnt_r <= '0;
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      power_control_r <= pwr_mode_pkg::POWER_CONTROL_RST;
    else if (state_nxt == pwr_mode_pkg::ST_RESET)
      power_control_r <= pwr_mode_pkg::POWER_CONTROL_RST;
    else if (state_r != pwr_mode_pkg::ST_RUN && state_nxt == pwr_mode_pkg::ST_RUN)
      power_control_r <= pwr_mode_pkg::POWER_CONTROL_RST;
    else if (wr_pc && state_r == pwr_mode_pkg::ST_RUN)
      power_control_r <= wb_dat_i[7:0];
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ext_int_flag_r <= pwr_mode_pkg::EXT_INT_FLAG_RST;
    else if (power_on_rst)
      ext_int_flag_r <= pwr_mode_pkg::EXT_INT_FLAG_RST;
    else if (state_nxt == pwr_mode_pkg::ST_RESET)
      ext_int_flag_r[pwr_mode_pkg::EF_KEEP_ALIVE_BIT] <= 1'b0;
    else if (wr_ef)
    begin
      ext_int_flag_r[pwr_mode_pkg::EF_KEEP_ALIVE_BIT] <= wb_dat_i[0];
      ext_int_flag_r[pwr_mode_pkg::EF_RING_SEL_BIT] <= wb_dat_i[1];
    end
  end

  // --------------------------------------------------------------
  // bus answer: one wait state, unmapped reads zero
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req && !wb_we_i)
    begin
      case (bus_idx)
        pwr_mode_pkg::IDX_POWER_CONTROL:
          wb_dat_o <= {24'h000000, power_control_r};
        pwr_mode_pkg::IDX_EXT_INT_FLAG:
          wb_dat_o <= {24'h000000, ext_int_flag_r};
        pwr_mode_pkg::IDX_MODE_STATUS:
          wb_dat_o <= {26'h0000000, wake_by_irq_r, state_r};
        default:
          wb_dat_o <= 32'h0000_0000;
      endcase
    end
    else
      wb_dat_o <= 32'h0000_0000;
  end

  // --------------------------------------------------------------
  // core and pin controls, all registered from next state
  // --------------------------------------------------------------
  logic asleep_nxt;
  assign asleep_nxt = state_nxt == pwr_mode_pkg::ST_IDLE || state_nxt == pwr_mode_pkg::ST_STOP ||
    state_nxt == pwr_mode_pkg::ST_WARM;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_hold <= 1'b0;
      core_rst <= 1'b1;
      clk_gate_off <= 1'b0;
      xtal_amp_en <= 1'b1;
      bandgap_en <= 1'b1;
      p0_drive_opcode <= 1'b0;
      p2_hold_latched <= 1'b0;
    end
    else
    begin
      core_hold <= asleep_nxt;
      core_rst <= state_nxt == pwr_mode_pkg::ST_RESET;
      clk_gate_off <= state_nxt == pwr_mode_pkg::ST_STOP;
      xtal_amp_en <= state_nxt != pwr_mode_pkg::ST_STOP;
      bandgap_en <= state_nxt != pwr_mode_pkg::ST_STOP || keep_alive;
      p0_drive_opcode <= state_nxt == pwr_mode_pkg::ST_IDLE && ext_program_exec;
      p2_hold_latched <= state_nxt == pwr_mode_pkg::ST_IDLE && ext_program_exec;
    end
  end

  // vector fetch keeps the stacked return address of the entry instruction
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      take_vector <= 1'b0;
      restart_zero <= 1'b0;
    end
    else
    begin
      take_vector <= state_nxt == pwr_mode_pkg::ST_RUN &&
        (state_r == pwr_mode_pkg::ST_IDLE || state_r == pwr_mode_pkg::ST_WARM);
      restart_zero <= state_r == pwr_mode_pkg::ST_RESET &&
        state_nxt == pwr_mode_pkg::ST_RUN;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_idle_entry: assert property (
    state_r == pwr_mode_pkg::ST_RUN && !run_rst && wr_pc && wb_dat_i[1:0] == 2'b01
    |=> state_r == pwr_mode_pkg::ST_IDLE && core_hold)
    else $error("idle not entered after control write");

  a_stop_wins: assert property (
    state_r == pwr_mode_pkg::ST_RUN && !run_rst && wr_pc && wb_dat_i[1:0] == 2'b11
    |=> state_r == pwr_mode_pkg::ST_STOP)
    else $error("stop did not win over idle");

  a_idle_irq_exit: assert property (
    state_r == pwr_mode_pkg::ST_IDLE && irq_enabled_any && !run_rst
    |=> take_vector && !core_hold && power_control_r[0] == 1'b0)
    else $error("idle interrupt exit wrong");

  a_stop_clocks_off: assert property (
    state_r == pwr_mode_pkg::ST_STOP |-> clk_gate_off && !xtal_amp_en && core_hold)
    else $error("clocks running in stop");

  a_wdt_no_stop_exit: assert property (
    state_r == pwr_mode_pkg::ST_STOP && wdt_rst && !ext_rst_pin && !power_on_rst &&
    !ext_irq && !(keep_alive && (supply_low_rst || pfail_irq))
    |=> state_r == pwr_mode_pkg::ST_STOP)
    else $error("watchdog left stop");

  a_pin_exits_stop: assert property (
    state_r == pwr_mode_pkg::ST_STOP && ext_rst_pin |=> state_r == pwr_mode_pkg::ST_WARM)
    else $error("reset pin did not leave stop");

  a_pfail_needs_bg: assert property (
    state_r == pwr_mode_pkg::ST_STOP && !keep_alive && !ext_irq &&
    !ext_rst_pin && !power_on_rst
    |=> state_r == pwr_mode_pkg::ST_STOP)
    else $error("stop left without keep-alive");

  a_warm_delay: assert property (
    state_r == pwr_mode_pkg::ST_WARM && !ring_sel && $past(state_r) == pwr_mode_pkg::ST_STOP
    |-> warm_cnt_r == '0 ##1 (state_r == pwr_mode_pkg::ST_WARM && warm_cnt_r == 1))
    else $error("warm counter not started");

  a_warm_end: assert property (
    state_r == pwr_mode_pkg::ST_WARM && warm_done && wake_by_irq_r |=> take_vector)
    else $error("vector not taken after stop wake");

  a_idle_reset: assert property (
    state_r == pwr_mode_pkg::ST_IDLE && run_rst |=> core_rst && power_control_r == 8'h00)
    else $error("reset did not clear idle");

  a_idle_clocks_on: assert property (
    state_r == pwr_mode_pkg::ST_IDLE |-> !clk_gate_off && xtal_amp_en && core_hold)
    else $error("clocks stopped in idle");

  a_reset_release: assert property (
    state_r == pwr_mode_pkg::ST_RESET && !run_rst
    |=> state_r == pwr_mode_pkg::ST_RUN && restart_zero && !core_rst)
    else $error("no prompt restart after reset");

  a_ring_kept: assert property (
    state_nxt == pwr_mode_pkg::ST_RESET && !power_on_rst
    |=> ring_sel == $past(ring_sel) && !keep_alive)
    else $error("ring select lost on reset");

  c_idle_wake: cover property (state_r == pwr_mode_pkg::ST_IDLE ##1 take_vector);
  c_idle_rst: cover property (state_r == pwr_mode_pkg::ST_IDLE ##1 core_rst);
  c_ring_fast: cover property (state_r == pwr_mode_pkg::ST_WARM && ring_sel ##1 take_vector);
  c_stop_irq: cover property (state_r == pwr_mode_pkg::ST_STOP ##1 state_r == pwr_mode_pkg::ST_WARM
    && wake_by_irq_r);
  c_stop_rst: cover property (state_r == pwr_mode_pkg::ST_WARM ##1 core_rst);

endmodule : pwr_mode_ctrl

// [verilog/pwr_mode_pkg.sv]
// constants and types for the idle and stop power mode controller
package pwr_mode_pkg;

  // --------------------------------------------------------------
  // register map, index form: byte address is four times the index
  // --------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_EXT_INT_FLAG = 8'h91;
  localparam logic [7:0] IDX_MODE_STATUS = 8'hA0;

  localparam int PC_IDLE_BIT = 0;
  localparam int PC_STOP_BIT = 1;
  localparam int EF_KEEP_ALIVE_BIT = 0;
  localparam int EF_RING_SEL_BIT = 1;

  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] EXT_INT_FLAG_RST = 8'h00;

  // --------------------------------------------------------------
  // timing: crystal restart delay in oscillator cycles
  // --------------------------------------------------------------
  localparam int WARM_CYCLES = 65536;
  localparam int WARM_CNT_W = 17;

  // --------------------------------------------------------------
  // mode states, one-hot
  // --------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_IDLE = 5'h02,
    ST_STOP = 5'h04,
    ST_WARM = 5'h08,
    ST_RESET = 5'h10
  } mode_state_t;

endpackage : pwr_mode_pkg
